// file: logic/ccso_core.sv
`timescale 1ns/1ps

module ccso_core
#(
  parameter int unsigned TIMER_PIN = 5
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [11:0] prog_word,
  input wire logic [7:0] dmem_rd_data,
  input wire logic [5:0] direction_control,
  input wire logic pin_wake_cause,
  input wire logic comparator_wake_cause,
  input wire logic watchdog_timeout,
  output logic [3:0] q_phase,
  output logic [9:0] prog_addr,
  output logic [7:0] dmem_addr,
  output logic [7:0] dmem_wr_data,
  output logic dmem_we,
  output logic [7:0] core_flags,
  output logic [7:0] accumulator,
  output logic sleep_mode,
  output logic [7:0] timer_pin_options,
  output logic [5:0] pullup_en,
  output logic [5:0] wake_en,
  output logic timer_pin_dir,
  output logic timer_source_pin,
  output logic timer_edge_falling,
  output logic prescaler_to_wdt,
  output logic [3:0] timer_div_exp,
  output logic [2:0] wdt_div_exp
);

  // ==========================================================
  // Phase generator
  ccso_pkg::ccso_phase_e phase_q;
  logic [3:0] q_phase_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_q <= ccso_pkg::CCSO_Q1;
      q_phase_q <= 4'h1;
    end
    else
    begin
      case (phase_q)
        ccso_pkg::CCSO_Q1:
        begin
          phase_q <= ccso_pkg::CCSO_Q2;
          q_phase_q <= 4'h2;
        end
        ccso_pkg::CCSO_Q2:
        begin
          phase_q <= ccso_pkg::CCSO_Q3;
          q_phase_q <= 4'h4;
        end
        ccso_pkg::CCSO_Q3:
        begin
          phase_q <= ccso_pkg::CCSO_Q4;
          q_phase_q <= 4'h8;
        end
        ccso_pkg::CCSO_Q4:
        begin
          phase_q <= ccso_pkg::CCSO_Q1;
          q_phase_q <= 4'h1;
        end
        default:
        begin
          phase_q <= ccso_pkg::CCSO_Q1;
          q_phase_q <= 4'h1;
        end
      endcase
    end
  end

  logic ph1;
  logic ph2;
  logic ph3;
  logic ph4;
  assign ph1 = (phase_q == ccso_pkg::CCSO_Q1);
  assign ph2 = (phase_q == ccso_pkg::CCSO_Q2);
  assign ph3 = (phase_q == ccso_pkg::CCSO_Q3);
  assign ph4 = (phase_q == ccso_pkg::CCSO_Q4);

  // ==========================================================
  // Wake cause capture after reset release
  logic [1:0] pin_sync_q;
  logic [1:0] cmp_sync_q;
  logic [1:0] boot_cnt_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_sync_q <= 2'h0;
      cmp_sync_q <= 2'h0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[0], pin_wake_cause};
      cmp_sync_q <= {cmp_sync_q[0], comparator_wake_cause};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boot_cnt_q <= 2'h0;
    end
    else if (boot_cnt_q != ccso_pkg::BOOT_DONE)
    begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
    end
  end

  // ==========================================================
  // Registers of the core
  logic [7:0] status_q;
  logic [7:0] option_q;
  logic [7:0] w_q;
  logic sleep_q;
  logic [9:0] pc_q;
  logic [9:0] fetch_addr_q;
  logic [11:0] ir_q;
  logic ir_valid_q;
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  logic z_q;
  logic dc_q;
  logic c_q;

  // ==========================================================
  // Decode of the executing word
  ccso_pkg::ccso_op_e op;
  logic [7:0] arg;
  logic exec;
  logic is_goto;
  logic writes_f;
  logic writes_w;
  logic [9:0] goto_target;

  assign op = ccso_pkg::ccso_op_e'(ir_q[ccso_pkg::OPC_HI:ccso_pkg::OPC_LO]);
  assign arg = ir_q[ccso_pkg::ARG_HI:ccso_pkg::ARG_LO];
  assign exec = ir_valid_q && !sleep_q;
  assign is_goto = exec && (op == ccso_pkg::CCSO_GOTO);
  assign writes_f = (op == ccso_pkg::CCSO_ADD) || (op == ccso_pkg::CCSO_SUB)
    || (op == ccso_pkg::CCSO_RRF) || (op == ccso_pkg::CCSO_RLF)
    || (op == ccso_pkg::CCSO_MOVWF);
  assign writes_w = (op == ccso_pkg::CCSO_ANDLW) || (op == ccso_pkg::CCSO_MOVLW)
    || (op == ccso_pkg::CCSO_MOVF);
  assign goto_target = {status_q[ccso_pkg::ST_PAGE], 1'b0, arg};

  // ==========================================================
  // Fetch stage
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pc_q <= '0;
      fetch_addr_q <= '0;
    end
    else if (!sleep_q)
    begin
      if (ph1)
      begin
        fetch_addr_q <= pc_q;
        pc_q <= pc_q + ccso_pkg::PC_STEP;
      end
      else if (ph4 && is_goto)
      begin
        pc_q <= goto_target;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ir_q <= '0;
      ir_valid_q <= 1'b0;
    end
    else if (ph4 && !sleep_q)
    begin
      ir_q <= prog_word;
      ir_valid_q <= !is_goto;
    end
  end

  // ==========================================================
  // Execute stage: operand read and arithmetic
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [4:0] nsum;
  logic [4:0] ndiff;
  assign sum9 = {1'b0, opnd_q} + {1'b0, w_q};
  assign diff9 = {1'b0, opnd_q} - {1'b0, w_q};
  assign nsum = {1'b0, opnd_q[3:0]} + {1'b0, w_q[3:0]};
  assign ndiff = {1'b0, opnd_q[3:0]} - {1'b0, w_q[3:0]};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      opnd_q <= '0;
    end
    else if (ph2 && exec)
    begin
      opnd_q <= (arg == ccso_pkg::STATUS_ADDR) ? status_q : dmem_rd_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      res_q <= '0;
      z_q <= 1'b0;
      dc_q <= 1'b0;
      c_q <= 1'b0;
    end
    else if (ph3 && exec)
    begin
      case (op)
        ccso_pkg::CCSO_ADD:
        begin
          res_q <= sum9[7:0];
          z_q <= (sum9[7:0] == 8'h00);
          dc_q <= nsum[ccso_pkg::NIB_W];
          c_q <= sum9[8];
        end
        ccso_pkg::CCSO_SUB:
        begin
          res_q <= diff9[7:0];
          z_q <= (diff9[7:0] == 8'h00);
          dc_q <= !ndiff[ccso_pkg::NIB_W];
          c_q <= !diff9[8];
        end
        ccso_pkg::CCSO_RRF:
        begin
          res_q <= {status_q[ccso_pkg::ST_C], opnd_q[7:1]};
          c_q <= opnd_q[0];
        end
        ccso_pkg::CCSO_RLF:
        begin
          res_q <= {opnd_q[6:0], status_q[ccso_pkg::ST_C]};
          c_q <= opnd_q[7];
        end
        ccso_pkg::CCSO_ANDLW:
        begin
          res_q <= w_q & arg;
          z_q <= ((w_q & arg) == 8'h00);
        end
        ccso_pkg::CCSO_MOVLW:
        begin
          res_q <= arg;
        end
        ccso_pkg::CCSO_MOVWF:
        begin
          res_q <= w_q;
        end
        ccso_pkg::CCSO_MOVF:
        begin
          res_q <= opnd_q;
          z_q <= (opnd_q == 8'h00);
        end
        default:
        begin
          res_q <= res_q;
        end
      endcase
    end
  end

  // ==========================================================
  // Destination write in phase four
  logic [7:0] dmem_addr_q;
  logic [7:0] dmem_wr_data_q;
  logic dmem_we_q;
  logic [7:0] res_next_f;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dmem_addr_q <= '0;
      dmem_wr_data_q <= '0;
      dmem_we_q <= 1'b0;
    end
    else
    begin
      dmem_we_q <= ph3 && exec && writes_f && (arg != ccso_pkg::STATUS_ADDR);
      if (ph1 && exec)
      begin
        dmem_addr_q <= arg;
      end
      if (ph3 && exec && writes_f)
      begin
        dmem_wr_data_q <= (op == ccso_pkg::CCSO_MOVWF) ? w_q : res_next_f;
      end
    end
  end

  always_comb
  begin
    case (op)
      ccso_pkg::CCSO_ADD: res_next_f = sum9[7:0];
      ccso_pkg::CCSO_SUB: res_next_f = diff9[7:0];
      ccso_pkg::CCSO_RRF: res_next_f = {status_q[ccso_pkg::ST_C], opnd_q[7:1]};
      ccso_pkg::CCSO_RLF: res_next_f = {opnd_q[6:0], status_q[ccso_pkg::ST_C]};
      default: res_next_f = w_q;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      w_q <= '0;
    end
    else if (ph4 && exec && writes_w)
    begin
      w_q <= res_q;
    end
  end

  // ==========================================================
  // Status register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_q <= ccso_pkg::STATUS_RESET;
    end
    else
    begin
      if (boot_cnt_q == ccso_pkg::BOOT_CAPTURE)
      begin
        status_q[ccso_pkg::ST_PIN_WAKE] <= pin_sync_q[1];
        status_q[ccso_pkg::ST_CMP_WAKE] <= cmp_sync_q[1];
      end
      if (ph4 && exec)
      begin
        if (writes_f && (arg == ccso_pkg::STATUS_ADDR))
        begin
          status_q <= (status_q & ~ccso_pkg::STATUS_SW_MASK)
            | (res_q & ccso_pkg::STATUS_SW_MASK);
        end
        case (op)
          ccso_pkg::CCSO_ADD, ccso_pkg::CCSO_SUB:
          begin
            status_q[ccso_pkg::ST_Z] <= z_q;
            status_q[ccso_pkg::ST_DC] <= dc_q;
            status_q[ccso_pkg::ST_C] <= c_q;
          end
          ccso_pkg::CCSO_RRF, ccso_pkg::CCSO_RLF:
          begin
            status_q[ccso_pkg::ST_C] <= c_q;
          end
          ccso_pkg::CCSO_ANDLW, ccso_pkg::CCSO_MOVF:
          begin
            status_q[ccso_pkg::ST_Z] <= z_q;
          end
          ccso_pkg::CCSO_WATCHDOG_CLEAR_INSTRUCTION:
          begin
            status_q[ccso_pkg::ST_TO] <= 1'b1;
            status_q[ccso_pkg::ST_PD] <= 1'b1;
          end
          ccso_pkg::CCSO_SLEEP:
          begin
            status_q[ccso_pkg::ST_TO] <= 1'b1;
            status_q[ccso_pkg::ST_PD] <= 1'b0;
          end
          default:
          begin
          end
        endcase
      end
      if (watchdog_timeout)
      begin
        status_q[ccso_pkg::ST_TO] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sleep and option register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_q <= 1'b0;
    end
    else if (ph4 && exec && (op == ccso_pkg::CCSO_SLEEP))
    begin
      sleep_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      option_q <= ccso_pkg::OPTION_RESET;
    end
    else if (ph4 && exec && (op == ccso_pkg::CCSO_OPTION))
    begin
      option_q <= w_q;
    end
  end

  // ==========================================================
  // Pin controls from option and direction
  logic [5:0] pullup_en_q;
  logic [5:0] wake_en_q;

  for (genvar i = 0; i < ccso_pkg::PIN_N; i++)
  begin : g_pin
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        pullup_en_q[i] <= 1'b0;
        wake_en_q[i] <= 1'b0;
      end
      else
      begin
        pullup_en_q[i] <= ccso_pkg::WAKE_PULL_PINS[i] && direction_control[i]
          && !option_q[ccso_pkg::OP_PULL_DIS];
        wake_en_q[i] <= ccso_pkg::WAKE_PULL_PINS[i] && direction_control[i]
          && !option_q[ccso_pkg::OP_WAKE_DIS];
      end
    end
  end

  logic timer_pin_dir_q;
  logic [3:0] timer_div_exp_q;
  logic [2:0] wdt_div_exp_q;
  logic [2:0] rate;
  assign rate = option_q[ccso_pkg::OP_RATE_HI:ccso_pkg::OP_RATE_LO];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timer_pin_dir_q <= 1'b1;
      timer_div_exp_q <= 4'h0;
      wdt_div_exp_q <= 3'h0;
    end
    else
    begin
      timer_pin_dir_q <= direction_control[TIMER_PIN] || option_q[ccso_pkg::OP_SRC];
      if (option_q[ccso_pkg::OP_PSA])
      begin
        timer_div_exp_q <= 4'h0;
        wdt_div_exp_q <= rate;
      end
      else
      begin
        timer_div_exp_q <= {1'b0, rate} + 4'h1;
        wdt_div_exp_q <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign q_phase = q_phase_q;
  assign prog_addr = fetch_addr_q;
  assign dmem_addr = dmem_addr_q;
  assign dmem_wr_data = dmem_wr_data_q;
  assign dmem_we = dmem_we_q;
  assign core_flags = status_q;
  assign accumulator = w_q;
  assign sleep_mode = sleep_q;
  assign timer_pin_options = option_q;
  assign pullup_en = pullup_en_q;
  assign wake_en = wake_en_q;
  assign timer_pin_dir = timer_pin_dir_q;
  assign timer_source_pin = option_q[ccso_pkg::OP_SRC];
  assign timer_edge_falling = option_q[ccso_pkg::OP_EDGE];
  assign prescaler_to_wdt = option_q[ccso_pkg::OP_PSA];
  assign timer_div_exp = timer_div_exp_q;
  assign wdt_div_exp = wdt_div_exp_q;

endmodule

// file: logic/ccso_pkg.sv
// Function
// - Input clock divided by four into four non-overlapping phases per cycle.
// - Program counter increments in phase one; fetched word latched in phase four.
// - Fetch one cycle, execute the previous word the next cycle.
// - Program counter changes take two cycles; the fetched word is discarded.
// - Latched instruction decodes and executes over phases one to four.
// - Operand read in phase two, destination written in phase four.
// - Status bit 7 set only after a pin-change wake-up reset; the core also lets a write to status address 03h set it.
// - Status bit 6 set only after a comparator wake-up reset; the core also lets a write to status address 03h set it.
// - Status bit 5 picks program page: 1 upper, 0 lower.
// - Power-down flag set by power-up or watchdog clear, cleared by sleep.
// - Zero flag set when arithmetic or logic result is zero.
// - Nibble flag is add nibble carry, or subtract nibble no-borrow.
// - Carry is add carry, subtract no-borrow, or rotated-out bit.
// - Option register is 8-bit write-only, loaded from accumulator by instruction.
// - Any reset sets all option bits to one.
// - Output direction disables weak pull-up and pin wake-up for that pin.
// - Timer source bit high forces the timer clock pin to input.
// - Option bits 7 and 6 disable pin wake-up and pull-ups, active high.
// - Option bit 4 high counts falling edges, low counts rising edges.
package ccso_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned PC_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WORD_W = 12;
  localparam int unsigned PIN_N = 6;
  localparam int unsigned NIB_W = 4;

  // ==========================================================
  // Addresses and reset values
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] STATUS_SW_MASK = 8'he7;
  localparam logic [5:0] WAKE_PULL_PINS = 6'h0b;
  localparam logic [9:0] PC_STEP = 10'h001;
  localparam logic [1:0] BOOT_CAPTURE = 2'h2;
  localparam logic [1:0] BOOT_DONE = 2'h3;

  // ==========================================================
  // Status field positions
  localparam int unsigned ST_PIN_WAKE = 7;
  localparam int unsigned ST_CMP_WAKE = 6;
  localparam int unsigned ST_PAGE = 5;
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_C = 0;

  // ==========================================================
  // Option field positions
  localparam int unsigned OP_WAKE_DIS = 7;
  localparam int unsigned OP_PULL_DIS = 6;
  localparam int unsigned OP_SRC = 5;
  localparam int unsigned OP_EDGE = 4;
  localparam int unsigned OP_PSA = 3;
  localparam int unsigned OP_RATE_HI = 2;
  localparam int unsigned OP_RATE_LO = 0;

  // ==========================================================
  // Instruction word fields
  localparam int unsigned OPC_HI = 11;
  localparam int unsigned OPC_LO = 8;
  localparam int unsigned ARG_HI = 7;
  localparam int unsigned ARG_LO = 0;

  typedef enum logic [1:0]
  {
    CCSO_Q1 = 2'b00,
    CCSO_Q2 = 2'b01,
    CCSO_Q3 = 2'b10,
    CCSO_Q4 = 2'b11
  } ccso_phase_e;

  typedef enum logic [3:0]
  {
    CCSO_NOP = 4'b0000,
    CCSO_ADD = 4'b0001,
    CCSO_SUB = 4'b0010,
    CCSO_RRF = 4'b0011,
    CCSO_RLF = 4'b0100,
    CCSO_ANDLW = 4'b0101,
    CCSO_MOVLW = 4'b0110,
    CCSO_MOVWF = 4'b0111,
    CCSO_MOVF = 4'b1000,
    CCSO_GOTO = 4'b1001,
    CCSO_OPTION = 4'b1010,
    CCSO_SLEEP = 4'b1011,
    CCSO_WATCHDOG_CLEAR_INSTRUCTION = 4'b1100
  } ccso_op_e;

endpackage

// file: tb/ccso_core_assertions.sv
`timescale 1ns/1ps

module ccso_core_assertions
#(
  parameter int unsigned TIMER_PIN = 5
)
(
  input logic ref_clk,
  input logic arst_n,
  input logic [5:0] direction_control,
  input logic [3:0] q_phase,
  input logic [9:0] prog_addr,
  input logic [7:0] dmem_addr,
  input logic dmem_we,
  input logic [7:0] core_flags,
  input logic [7:0] accumulator,
  input logic sleep_mode,
  input logic [7:0] timer_pin_options,
  input logic [5:0] pullup_en,
  input logic [5:0] wake_en,
  input logic timer_pin_dir,
  input logic [3:0] timer_div_exp,
  input logic [2:0] wdt_div_exp
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Sequencer
  AST_PHASE: assert property (!sleep_mode ##1 !sleep_mode |-> $onehot(q_phase) &&
    q_phase == {$past(q_phase[2:0]), $past(q_phase[3])})
    else $error("phase did not rotate");
  AST_PC_HOLD: assert property (q_phase != 4'h1 |=> $stable(prog_addr))
    else $error("fetch address moved outside first phase");
  AST_OPERAND: assert property (q_phase == 4'h2 |=> $stable(dmem_addr) [*2])
    else $error("operand address moved during execute");
  AST_WR_Q4: assert property (dmem_we |-> q_phase == 4'h8 ##1 !dmem_we)
    else $error("write strobe outside fourth phase");
  AST_WR_STATUS: assert property (dmem_we |-> dmem_addr != 8'h03)
    else $error("status address written externally");

  // ==========================================================
  // Status and option
  AST_OPT_LOAD: assert property ($changed(timer_pin_options) |->
    $past(q_phase) == 4'h8 && timer_pin_options == $past(accumulator))
    else $error("option changed without accumulator copy");
  AST_RST_VAL: assert property ($rose(arst_n) |-> timer_pin_options == 8'hff &&
    core_flags == 8'h18 && prog_addr == 10'h000)
    else $error("reset values wrong");
  AST_SLEEP_PD: assert property ($rose(sleep_mode) |-> core_flags[3] == 1'b0)
    else $error("power-down flag not cleared by sleep");
  AST_PIN_DIR: assert property (1 |=> timer_pin_dir ==
    ($past(timer_pin_options[5]) | $past(direction_control[TIMER_PIN])))
    else $error("timer pin direction wrong");
  AST_PULL: assert property (1 |=>
    pullup_en == ($past(timer_pin_options[6]) ? 6'h00 : $past(direction_control) & 6'h0b) &&
    wake_en == ($past(timer_pin_options[7]) ? 6'h00 : $past(direction_control) & 6'h0b))
    else $error("pull-up or wake enable wrong");
  AST_DIV: assert property (1 |=>
    timer_div_exp == ($past(timer_pin_options[3]) ? 4'h0 :
    {1'b0, $past(timer_pin_options[2:0])} + 4'h1) &&
    wdt_div_exp == ($past(timer_pin_options[3]) ? $past(timer_pin_options[2:0]) : 3'h0))
    else $error("prescaler division wrong");

  // ==========================================================
  // Coverage
  COV_WRITE: cover property (dmem_we);
  COV_SLEEP: cover property ($rose(sleep_mode));
  COV_OPTION: cover property ($changed(timer_pin_options));
endmodule

bind ccso_core ccso_core_assertions #(.TIMER_PIN(TIMER_PIN)) chk_u
(
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .direction_control(direction_control),
  .q_phase(q_phase),
  .prog_addr(prog_addr),
  .dmem_addr(dmem_addr),
  .dmem_we(dmem_we),
  .core_flags(core_flags),
  .accumulator(accumulator),
  .sleep_mode(sleep_mode),
  .timer_pin_options(timer_pin_options),
  .pullup_en(pullup_en),
  .wake_en(wake_en),
  .timer_pin_dir(timer_pin_dir),
  .timer_div_exp(timer_div_exp),
  .wdt_div_exp(wdt_div_exp)
);

// file: tb/ccso_core_tb.sv
`timescale 1ns/1ps

module ccso_core_tb;
  // ==========================================================
  // Signals
  logic ref_clk;
  logic arst_n;
  logic [11:0] prog_word;
  logic [7:0] dmem_rd_data;
  logic [5:0] direction_control;
  logic pin_wake_cause;
  logic comparator_wake_cause;
  logic [3:0] q_phase;
  logic [9:0] prog_addr;
  logic [7:0] dmem_addr;
  logic [7:0] dmem_wr_data;
  logic dmem_we;
  logic [7:0] core_flags;
  logic [7:0] accumulator;
  logic sleep_mode;
  logic [7:0] timer_pin_options;
  logic [5:0] pullup_en;
  logic [5:0] wake_en;
  logic timer_pin_dir;
  logic timer_source_pin;
  logic timer_edge_falling;
  logic prescaler_to_wdt;
  logic [3:0] timer_div_exp;
  logic [2:0] wdt_div_exp;
  logic [11:0] rom [1024];
  logic [7:0] ram [256];
  logic [15:0] expq [$];
  logic [9:0] pc;
  int n_errors;
  int cmp_count;

  ccso_core dut_u
  (
    .ref_clk,
    .arst_n,
    .prog_word,
    .dmem_rd_data,
    .direction_control,
    .pin_wake_cause,
    .comparator_wake_cause,
    .watchdog_timeout(1'b0),
    .q_phase,
    .prog_addr,
    .dmem_addr,
    .dmem_wr_data,
    .dmem_we,
    .core_flags,
    .accumulator,
    .sleep_mode,
    .timer_pin_options,
    .pullup_en,
    .wake_en,
    .timer_pin_dir,
    .timer_source_pin,
    .timer_edge_falling,
    .prescaler_to_wdt,
    .timer_div_exp,
    .wdt_div_exp
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Memories and write monitor
  always @(negedge ref_clk)
  begin
    prog_word <= rom[prog_addr];
    dmem_rd_data <= ram[dmem_addr];
  end

  always @(negedge ref_clk)
  begin
    if (arst_n === 1'b1 && dmem_we === 1'b1)
    begin
      ram[dmem_addr] <= dmem_wr_data;
      if (expq.size() == 0)
        chk("write", 16'hxxxx, {dmem_addr, dmem_wr_data});
      else
        chk("write", expq.pop_front(), {dmem_addr, dmem_wr_data});
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ins(input logic [3:0] op, input logic [7:0] k);
    rom[pc] = {op, k};
    pc++;
  endtask

  task automatic expw(input logic [7:0] a, input logic [7:0] d);
    expq.push_back({a, d});
  endtask

  task automatic start();
    @(negedge ref_clk);
    arst_n = 1'b0;
    pc = 10'h000;
    foreach (rom[i]) rom[i] = 12'h000;
  endtask

  task automatic go(input string nm);
    repeat (4) @(negedge ref_clk);
    arst_n = 1'b1;
    for (int i = 0; i < 4000 && expq.size() != 0; i++) @(negedge ref_clk);
    repeat (24) @(negedge ref_clk);
    chk("pending writes", 16'h0000, 16'(expq.size()));
    expq.delete();
    $display("Test %s done", nm);
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("ERROR watchdog expected done seen hang");
    final_report();
  end

  // ==========================================================
  // Tests
  initial
  begin
    logic [7:0] a, b, k, r;
    logic [8:0] s;
    logic [4:0] h;
    bit sb;
    arst_n = 1'b0;
    direction_control = 6'h3f;
    pin_wake_cause = 1'b0;
    comparator_wake_cause = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    r = $urandom(32'h7bb4);
    start();
    for (int i = 0; i < 8; i++)
    begin
      sb = i[0];
      a = (i < 2) ? 8'h88 : 8'($urandom);
      b = (i < 2) ? 8'h78 : 8'($urandom);
      s = sb ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      h = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
      ins(ccso_pkg::CCSO_MOVLW, a);
      ins(ccso_pkg::CCSO_MOVWF, 8'h10);
      expw(8'h10, a);
      ins(ccso_pkg::CCSO_MOVLW, b);
      ins(sb ? ccso_pkg::CCSO_SUB : ccso_pkg::CCSO_ADD, 8'h10);
      expw(8'h10, s[7:0]);
      ins(ccso_pkg::CCSO_MOVF, 8'h03);
      ins(ccso_pkg::CCSO_MOVWF, 8'h20);
      expw(8'h20, {5'h03, s[7:0] == 8'h00, h[4] ^ sb, s[8] ^ sb});
    end
    go("add and subtract");
    start();
    r = $urandom;
    ins(ccso_pkg::CCSO_MOVLW, 8'h01);
    ins(ccso_pkg::CCSO_MOVWF, 8'h03);
    ins(ccso_pkg::CCSO_MOVLW, r);
    ins(ccso_pkg::CCSO_MOVWF, 8'h12);
    expw(8'h12, r);
    ins(ccso_pkg::CCSO_RRF, 8'h12);
    expw(8'h12, {1'b1, r[7:1]});
    ins(ccso_pkg::CCSO_RLF, 8'h12);
    expw(8'h12, r);
    ins(ccso_pkg::CCSO_MOVLW, r);
    ins(ccso_pkg::CCSO_ANDLW, ~r);
    ins(ccso_pkg::CCSO_MOVWF, 8'h13);
    expw(8'h13, 8'h00);
    ins(ccso_pkg::CCSO_WATCHDOG_CLEAR_INSTRUCTION, 8'h00);
    ins(ccso_pkg::CCSO_MOVF, 8'h03);
    ins(ccso_pkg::CCSO_MOVWF, 8'h23);
    expw(8'h23, 8'h1d);
    go("rotate and zero");
    start();
    ins(ccso_pkg::CCSO_MOVLW, 8'h20);
    ins(ccso_pkg::CCSO_MOVWF, 8'h03);
    ins(ccso_pkg::CCSO_GOTO, 8'h40);
    ins(ccso_pkg::CCSO_MOVWF, 8'h30);
    pc = 10'h240;
    ins(ccso_pkg::CCSO_MOVWF, 8'h31);
    expw(8'h31, 8'h20);
    ins(ccso_pkg::CCSO_MOVF, 8'h03);
    ins(ccso_pkg::CCSO_MOVWF, 8'h32);
    expw(8'h32, 8'h38);
    go("branch and page");
    start();
    direction_control = 6'($urandom) & 6'h1f;
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom;
      k = (i == 7) ? {3'h0, r[4], 4'h7} : {r[7:3], i[2:0]};
      ins(ccso_pkg::CCSO_MOVLW, k);
      ins(ccso_pkg::CCSO_OPTION, 8'h00);
    end
    ins(ccso_pkg::CCSO_MOVWF, 8'h50);
    expw(8'h50, k);
    ins(ccso_pkg::CCSO_SLEEP, 8'h00);
    ins(ccso_pkg::CCSO_MOVWF, 8'h51);
    go("option and sleep");
    chk("option", {8'h00, k}, {8'h00, timer_pin_options});
    chk("pullups", 16'(direction_control & 6'h0b), 16'(pullup_en));
    chk("wake enables", 16'(direction_control & 6'h0b), 16'(wake_en));
    chk("timer div", 16'h0008, 16'(timer_div_exp));
    chk("wdt div", 16'h0000, 16'(wdt_div_exp));
    chk("src edge psa", 16'(k[5:3]),
      16'({timer_source_pin, timer_edge_falling, prescaler_to_wdt}));
    chk("timer pin dir", 16'h0000, 16'(timer_pin_dir));
    chk("sleep pd", 16'h0002, 16'({sleep_mode, core_flags[3]}));
    for (int i = 0; i < 2; i++)
    begin
      start();
      pin_wake_cause = ~i[0];
      comparator_wake_cause = i[0];
      go("wake cause");
      chk("flags", i ? 16'h0058 : 16'h0098, {8'h00, core_flags});
      chk("option reset", 16'h00ff, {8'h00, timer_pin_options});
    end
    final_report();
  end
endmodule
